/* File: dram_area_cfg.svh */
// Purpose: Offsets, field positions, reset values and widths of the DRAM area control block.
// Assumes: Byte-wide register port with an 8-bit address.
// Notes: Definitions only.
`ifndef DRAM_AREA_CFG_SVH
`define DRAM_AREA_CFG_SVH

`define DAC_OFF_CTRL_A 8'h00
`define DAC_OFF_CTRL_B 8'h01
`define DAC_OFF_TMR_CSR 8'h02
`define DAC_OFF_TMR_CNT 8'h03
`define DAC_OFF_TMR_COR 8'h04

`define DAC_RST_CTRL_A 8'h10
`define DAC_RST_CTRL_B 8'h08
`define DAC_RST_TMR_CNT 8'h00
`define DAC_RST_TMR_COR 8'hff
`define DAC_RST_CKS 3'h0
`define DAC_READ_UNMAPPED 8'h00

`define DAC_A_SEL_HI 7
`define DAC_A_SEL_LO 5
`define DAC_A_RSVD 4
`define DAC_A_BURST 3
`define DAC_A_ROW_DOWN 2
`define DAC_A_SELF_REF 1
`define DAC_A_REFRESH_PIN_EN 0
`define DAC_B_RSVD 3
`define DAC_CSR_CMF 7
`define DAC_CSR_COMPARE_MATCH_IRQ_ENABLE 6
`define DAC_CSR_CKS_HI 5
`define DAC_CSR_CKS_LO 3
`define DAC_CSR_RSVD_MASK 8'h07

`endif

/* File: dram_area_pkg.sv */
// Purpose: Types and shared decoding for the DRAM area control block.
// Assumes: Nothing beyond the constants header.
// Notes: No constants live here; they are macros in the header.
package dram_area_pkg;
    typedef logic [2:0] area_code_type;
    typedef logic [1:0] cs_index_type;
    typedef enum logic {SR_NORMAL, SR_ACTIVE} refresh_state_type;

    // Any nonzero area code in expanded mode turns some area into DRAM space.
    function automatic logic code_is_dram(input area_code_type code, input logic expanded);
        code_is_dram = expanded && (code != 3'h0);
    endfunction
endpackage

/* File: dram_map_if.sv */
// Purpose: Carries the area code to the decoder and the decoded area map back.
// Assumes: Same clock domain on both sides; the map is combinational.
// Notes: Strobe index 0 to 3 stands for chip selects two to five.
`timescale 1ns/1ps
`default_nettype none
interface dram_map_if;
    import dram_area_pkg::*;
    area_code_type code;
    logic expanded;
    logic [3:0] areas;
    cs_index_type strobe [4];
    logic [3:0] cs_used;
    modport decoder (input code, input expanded, output areas, output strobe, output cs_used);
    modport user (output code, output expanded, input areas, input strobe, input cs_used);
endinterface
`default_nettype wire

/* File: dram_sync2.sv */
// Purpose: Two-flop synchroniser for levels arriving from pins.
// Assumes: Inputs are slow levels, not pulses.
// Notes: Only the second stage is visible outside.
`timescale 1ns/1ps
`default_nettype none
module dram_sync2 #(
    parameter int WIDTH = 3
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

/* File: dram_area_decode.sv */
// Purpose: Turns the area code into DRAM areas, row strobe pins per area and pins in use.
// Assumes: Caller registers the results.
// Notes: Outside expanded mode every area is normal.
`timescale 1ns/1ps
`default_nettype none
module dram_area_decode
    import dram_area_pkg::*;
(
    dram_map_if.decoder map
);
    always_comb begin
        map.areas = 4'h0;
        map.strobe = '{2'h0, 2'h1, 2'h2, 2'h3};
        map.cs_used = 4'h0;
        if (map.expanded) begin
            case (map.code)
                3'h1: begin
                    map.areas = 4'h1;
                    map.cs_used = 4'h1;
                end
                3'h2: begin
                    map.areas = 4'h3;
                    map.cs_used = 4'h3;
                end
                3'h3: begin
                    map.areas = 4'h3;
                    map.strobe[1] = 2'h0;
                    map.cs_used = 4'h1;
                end
                3'h4: begin
                    map.areas = 4'h7;
                    map.cs_used = 4'h7;
                end
                3'h5: begin
                    map.areas = 4'hf;
                    map.cs_used = 4'hf;
                end
                3'h6: begin
                    map.areas = 4'hf;
                    map.strobe = '{2'h0, 2'h0, 2'h2, 2'h2};
                    map.cs_used = 4'h5;
                end
                3'h7: begin
                    map.areas = 4'hf;
                    map.strobe = '{2'h0, 2'h0, 2'h0, 2'h0};
                    map.cs_used = 4'h1;
                end
                default: begin
                    map.areas = 4'h0;
                    map.cs_used = 4'h0;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: dram_area_control.sv */
// Purpose: DRAM area selection, burst and refresh mode control with its write lock.
// Assumes: One 50 MHz clock; mode and standby levels come from pins; the refresh tick is on-chip.
// Notes: Hardware standby reloads every register; software standby keeps them except the compare flag and compare interrupt enable, which it clears.
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "dram_area_cfg.svh"

// Notes on behaviour
// [R01] Control A loads 10h; software standby keeps.
// [R02] Bits 7-5 pick DRAM areas, expanded only.
// [R03] Codes map areas, each own row strobe except the R04 codes.
// [R04] Codes 011,110,111 share strobe pins.
// [R05] Unused chip selects released to port logic.
// [R06] Nonzero code locks control B and timer.
// [R07] Compare flag clear still works when locked.
// [R08] Software changes nonzero code only to zero; the code lets control A take any code at any time.
// [R09] Bit 4 reads one, ignores writes.
// [R10] Burst bit selects fast page accesses.
// [R11] Row-down bit holds strobe low between bursts.
// [R12] Self-refresh in standby when DRAM and enabled.
// [R13] Leaving standby restores normal access always.
// [R14] Refresh-pin enable drives refresh pin out.
// [R15] Software sets refresh pin only with DRAM; the code lets bit 0 drive the pin whatever the area code.
// [R16] Control B ignored while area code zero.
// [R17] Compare interrupt enable forced zero with DRAM.
// [R18] Byte access updates all fields together.
module dram_area_control
    import dram_area_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    input wire logic expanded_mode_in,
    input wire logic sw_standby_in,
    input wire logic hw_standby_in,
    input wire logic refresh_tick_in,
    output logic [7:0] rd_data_out,
    output logic [3:0] area_dram_out,
    output logic [7:0] area_strobe_out,
    output logic [3:0] cs_row_strobe_out,
    output logic [3:0] cs_port_release_out,
    output logic burst_mode_out,
    output logic row_down_hold_out,
    output logic self_refresh_out,
    output logic refresh_pin_out_en_out,
    output logic [7:0] ctrl_b_effective_out,
    output logic compare_match_flag_out,
    output logic cmi_enable_out
);
    logic expanded_s;
    logic sw_standby_s;
    logic hw_standby_s;
    logic [7:0] ctrl_a_q;
    logic [7:0] ctrl_b_q;
    logic cmf_q;
    logic cmf_seen_q;
    logic compare_match_irq_enable_q;
    logic [2:0] cks_q;
    logic [7:0] cnt_q;
    logic [7:0] cor_q;
    logic dram_any;
    logic locked;
    logic wr_a;
    logic wr_b;
    logic wr_csr;
    logic wr_cnt;
    logic wr_cor;
    logic match;
    logic [7:0] csr_view;
    refresh_state_type state_q;
    refresh_state_type state_d;
    dram_map_if map ();

    dram_sync2 #(.WIDTH(3)) u_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .async_in({expanded_mode_in, sw_standby_in, hw_standby_in}),
        .sync_out({expanded_s, sw_standby_s, hw_standby_s})
    );

    dram_area_decode u_decode (
        .map(map)
    );

    assign map.code = ctrl_a_q[`DAC_A_SEL_HI:`DAC_A_SEL_LO]; // [R02]
    assign map.expanded = expanded_s;
    assign dram_any = code_is_dram(ctrl_a_q[`DAC_A_SEL_HI:`DAC_A_SEL_LO], expanded_s);
    // The lock and the DRAM-space test are the same condition.
    assign locked = code_is_dram(ctrl_a_q[`DAC_A_SEL_HI:`DAC_A_SEL_LO], expanded_s); // [R06]
    assign wr_a = wr_en_in && (addr_in == `DAC_OFF_CTRL_A);
    assign wr_b = wr_en_in && (addr_in == `DAC_OFF_CTRL_B) && !locked; // [R06]
    assign wr_csr = wr_en_in && (addr_in == `DAC_OFF_TMR_CSR);
    assign wr_cnt = wr_en_in && (addr_in == `DAC_OFF_TMR_CNT) && !locked; // [R06]
    assign wr_cor = wr_en_in && (addr_in == `DAC_OFF_TMR_COR) && !locked; // [R06]
    assign match = refresh_tick_in && (cnt_q == cor_q);
    assign csr_view = {cmf_q, compare_match_irq_enable_q, cks_q, 3'h0} | `DAC_CSR_RSVD_MASK;

    // The whole byte lands in one edge; the reserved bit is forced to one as it is stored.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_a_q <= `DAC_RST_CTRL_A; // [R01]
        end else if (hw_standby_s) begin
            ctrl_a_q <= `DAC_RST_CTRL_A; // [R01]
        end else if (wr_a) begin
            ctrl_a_q <= wr_data_in | `DAC_RST_CTRL_A; // [R09] [R18]
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_b_q <= `DAC_RST_CTRL_B;
        end else if (hw_standby_s) begin
            ctrl_b_q <= `DAC_RST_CTRL_B;
        end else if (wr_b) begin
            ctrl_b_q <= wr_data_in | `DAC_RST_CTRL_B;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cks_q <= `DAC_RST_CKS;
            compare_match_irq_enable_q <= 1'b0;
        end else if (hw_standby_s) begin
            cks_q <= `DAC_RST_CKS;
            compare_match_irq_enable_q <= 1'b0;
        end else begin
            if (wr_csr && !locked) begin
                cks_q <= wr_data_in[`DAC_CSR_CKS_HI:`DAC_CSR_CKS_LO];
                compare_match_irq_enable_q <= wr_data_in[`DAC_CSR_COMPARE_MATCH_IRQ_ENABLE];
            end
            if (dram_any || sw_standby_s) begin
                compare_match_irq_enable_q <= 1'b0; // [R17]
            end
        end
    end

    // A compare match in the same edge as a clear keeps the flag set.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cmf_q <= 1'b0;
            cmf_seen_q <= 1'b0;
        end else if (hw_standby_s || sw_standby_s) begin
            cmf_q <= 1'b0;
            cmf_seen_q <= 1'b0;
        end else begin
            if (rd_en_in && (addr_in == `DAC_OFF_TMR_CSR) && cmf_q) begin
                cmf_seen_q <= 1'b1;
            end
            if (wr_csr && cmf_seen_q && !wr_data_in[`DAC_CSR_CMF]) begin
                cmf_q <= 1'b0; // [R07]
                cmf_seen_q <= 1'b0;
            end
            if (match) begin
                cmf_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_q <= `DAC_RST_TMR_CNT;
        end else if (hw_standby_s) begin
            cnt_q <= `DAC_RST_TMR_CNT;
        end else if (wr_cnt) begin
            cnt_q <= wr_data_in;
        end else if (match) begin
            cnt_q <= `DAC_RST_TMR_CNT;
        end else if (refresh_tick_in) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cor_q <= `DAC_RST_TMR_COR;
        end else if (hw_standby_s) begin
            cor_q <= `DAC_RST_TMR_COR;
        end else if (wr_cor) begin
            cor_q <= wr_data_in;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_data_out <= `DAC_READ_UNMAPPED;
        end else if (rd_en_in) begin
            case (addr_in)
                `DAC_OFF_CTRL_A: rd_data_out <= ctrl_a_q; // [R09]
                `DAC_OFF_CTRL_B: rd_data_out <= ctrl_b_q;
                `DAC_OFF_TMR_CSR: rd_data_out <= csr_view;
                `DAC_OFF_TMR_CNT: rd_data_out <= cnt_q;
                `DAC_OFF_TMR_COR: rd_data_out <= cor_q;
                default: rd_data_out <= `DAC_READ_UNMAPPED;
            endcase
        end else begin
            rd_data_out <= `DAC_READ_UNMAPPED;
        end
    end

    // Registered copy of the area map so the pin muxes see no decode glitches.
    generate
        for (genvar i = 0; i < 4; i++) begin : g_area
            always_ff @(posedge clk_in or posedge rst_in) begin
                if (rst_in) begin
                    area_dram_out[i] <= 1'b0;
                    area_strobe_out[2*i+1:2*i] <= 2'h0;
                    cs_row_strobe_out[i] <= 1'b0;
                    cs_port_release_out[i] <= 1'b1;
                end else begin
                    area_dram_out[i] <= map.areas[i]; // [R03]
                    area_strobe_out[2*i+1:2*i] <= map.strobe[i]; // [R04]
                    cs_row_strobe_out[i] <= map.cs_used[i];
                    cs_port_release_out[i] <= !map.cs_used[i]; // [R05]
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            burst_mode_out <= 1'b0;
            row_down_hold_out <= 1'b0;
            refresh_pin_out_en_out <= 1'b0;
            ctrl_b_effective_out <= 8'h00;
            compare_match_flag_out <= 1'b0;
            cmi_enable_out <= 1'b0;
        end else begin
            burst_mode_out <= dram_any && ctrl_a_q[`DAC_A_BURST]; // [R10]
            row_down_hold_out <= dram_any && ctrl_a_q[`DAC_A_BURST] && ctrl_a_q[`DAC_A_ROW_DOWN]; // [R11]
            refresh_pin_out_en_out <= ctrl_a_q[`DAC_A_REFRESH_PIN_EN]; // [R14]
            ctrl_b_effective_out <= dram_any ? ctrl_b_q : 8'h00; // [R16]
            compare_match_flag_out <= cmf_q;
            cmi_enable_out <= compare_match_irq_enable_q && !dram_any; // [R17]
        end
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            SR_NORMAL: begin
                if (sw_standby_s && dram_any && ctrl_a_q[`DAC_A_SELF_REF]) begin
                    state_d = SR_ACTIVE; // [R12]
                end
            end
            SR_ACTIVE: begin
                if (!sw_standby_s) begin
                    state_d = SR_NORMAL; // [R13]
                end
            end
            default: state_d = SR_NORMAL;
        endcase
        if (hw_standby_s) begin
            state_d = SR_NORMAL;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= SR_NORMAL;
            self_refresh_out <= 1'b0;
        end else begin
            state_q <= state_d;
            self_refresh_out <= (state_d == SR_ACTIVE);
        end
    end

    property p_hw_standby_reload;
        @(posedge clk_in) disable iff (rst_in) hw_standby_s |=> (ctrl_a_q == `DAC_RST_CTRL_A);
    endproperty
    a_hw_standby_reload: assert property (p_hw_standby_reload) // [R01]
        else $error("control A not reloaded in hardware standby");

    property p_rsvd_reads_one;
        @(posedge clk_in) disable iff (rst_in)
            (rd_en_in && addr_in == `DAC_OFF_CTRL_A) |=> rd_data_out[`DAC_A_RSVD];
    endproperty
    a_rsvd_reads_one: assert property (p_rsvd_reads_one) // [R09]
        else $error("reserved bit of control A read as zero");

    property p_lock_b;
        @(posedge clk_in) disable iff (rst_in)
            (locked && wr_en_in && addr_in == `DAC_OFF_CTRL_B && !hw_standby_s) |=> $stable(ctrl_b_q);
    endproperty
    a_lock_b: assert property (p_lock_b) // [R06]
        else $error("control B changed while locked");

    property p_lock_cor;
        @(posedge clk_in) disable iff (rst_in)
            (locked && !hw_standby_s) |=> (cor_q == $past(cor_q));
    endproperty
    a_lock_cor: assert property (p_lock_cor) // [R06]
        else $error("timer constant changed while locked");

    property p_cmf_clear_locked;
        @(posedge clk_in) disable iff (rst_in)
            (locked && wr_csr && cmf_seen_q && !wr_data_in[`DAC_CSR_CMF] && !match) |=> !cmf_q ##1 !compare_match_flag_out;
    endproperty
    a_cmf_clear_locked: assert property (p_cmf_clear_locked) // [R07]
        else $error("compare flag not cleared under lock");

    property p_compare_match_irq_enable_forced;
        @(posedge clk_in) disable iff (rst_in) dram_any |=> !compare_match_irq_enable_q ##1 !cmi_enable_out;
    endproperty
    a_compare_match_irq_enable_forced: assert property (p_compare_match_irq_enable_forced) // [R17]
        else $error("compare interrupt enable set with DRAM space");

    property p_self_refresh_exit;
        @(posedge clk_in) disable iff (rst_in) (self_refresh_out && !sw_standby_s) |=> !self_refresh_out;
    endproperty
    a_self_refresh_exit: assert property (p_self_refresh_exit) // [R13]
        else $error("self-refresh held after standby ended");

    property p_self_refresh_entry;
        @(posedge clk_in) disable iff (rst_in)
            (sw_standby_s && dram_any && ctrl_a_q[`DAC_A_SELF_REF] && !hw_standby_s) |=> self_refresh_out;
    endproperty
    a_self_refresh_entry: assert property (p_self_refresh_entry) // [R12]
        else $error("self-refresh not entered in standby");

    property p_ctrl_b_idle;
        @(posedge clk_in) disable iff (rst_in) !dram_any |=> (ctrl_b_effective_out == 8'h00);
    endproperty
    a_ctrl_b_idle: assert property (p_ctrl_b_idle) // [R16]
        else $error("control B effective without DRAM space");

    property p_row_down_needs_burst;
        @(posedge clk_in) disable iff (rst_in) row_down_hold_out |-> burst_mode_out && $past(ctrl_a_q[`DAC_A_ROW_DOWN]);
    endproperty
    a_row_down_needs_burst: assert property (p_row_down_needs_burst) // [R11]
        else $error("row strobe held low without burst mode");

    // A pin that carries the row strobe of area 0 or area 3 must never be handed back to the port logic.
    property p_release_unused;
        @(posedge clk_in) disable iff (rst_in)
            (area_dram_out[0] -> !cs_port_release_out[area_strobe_out[1:0]])
            && (area_dram_out[3] -> !cs_port_release_out[area_strobe_out[7:6]]);
    endproperty
    a_release_unused: assert property (p_release_unused) // [R05]
        else $error("row strobe pin released to port logic");

    property p_refresh_pin;
        @(posedge clk_in) disable iff (rst_in) ##1 (refresh_pin_out_en_out == $past(ctrl_a_q[`DAC_A_REFRESH_PIN_EN]));
    endproperty
    a_refresh_pin: assert property (p_refresh_pin) // [R14]
        else $error("refresh pin enable does not follow its bit");
endmodule
`default_nettype wire

/* File: dram_chip_model.sv */
// Purpose: Behavioural stand-in for the DRAM chips hung on the row strobe pins.
// Assumes: One chip per chip select pin; row strobe use and self-refresh arrive as levels.
// Notes: Reports which chips are holding their contents by self-refresh.
`timescale 1ns/1ps
`default_nettype none
module dram_chip_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [3:0] row_strobe_in,
    input wire logic self_refresh_in,
    output logic [3:0] refreshing_out
);
    // A chip enters self-refresh only while its pin is a row strobe and the controller asks for it.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            refreshing_out <= 4'h0;
        end else begin
            refreshing_out <= row_strobe_in & {4{self_refresh_in}};
        end
    end
endmodule
`default_nettype wire

/* File: test_dram_area_control.sv */
// Purpose: Self-checking bench for the DRAM area control block.
// Assumes: Byte register port with read data one cycle after the strobe.
// Notes: Pin levels pass two sync flops, so each level change is followed by a short settle.
`timescale 1ns/1ps
`default_nettype none
`include "dram_area_cfg.svh"
module test_dram_area_control
    import dram_area_pkg::*;
;
    logic clk_in, rst_in, wr_en_in, rd_en_in, expanded_mode_in, sw_standby_in, hw_standby_in, refresh_tick_in;
    logic [7:0] addr_in, wr_data_in, rd_data_out, area_strobe_out, ctrl_b_effective_out, rd;
    logic [3:0] area_dram_out, cs_row_strobe_out, cs_port_release_out, refreshing;
    logic burst_mode_out, row_down_hold_out, self_refresh_out, refresh_pin_out_en_out;
    logic compare_match_flag_out, cmi_enable_out;
    int mismatches, comparisons;
    localparam logic [3:0] AREAS [8] = '{4'h0, 4'h1, 4'h3, 4'h3, 4'h7, 4'hf, 4'hf, 4'hf};
    localparam logic [3:0] PINS [8] = '{4'h0, 4'h1, 4'h3, 4'h1, 4'h7, 4'hf, 4'h5, 4'h1};
    localparam logic [7:0] STROBES [8] = '{8'he4, 8'he4, 8'he4, 8'he0, 8'he4, 8'he4, 8'ha0, 8'h00};

    dram_area_control uut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
        .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .expanded_mode_in(expanded_mode_in),
        .sw_standby_in(sw_standby_in), .hw_standby_in(hw_standby_in), .refresh_tick_in(refresh_tick_in),
        .rd_data_out(rd_data_out), .area_dram_out(area_dram_out), .area_strobe_out(area_strobe_out),
        .cs_row_strobe_out(cs_row_strobe_out), .cs_port_release_out(cs_port_release_out),
        .burst_mode_out(burst_mode_out), .row_down_hold_out(row_down_hold_out),
        .self_refresh_out(self_refresh_out), .refresh_pin_out_en_out(refresh_pin_out_en_out),
        .ctrl_b_effective_out(ctrl_b_effective_out), .compare_match_flag_out(compare_match_flag_out),
        .cmi_enable_out(cmi_enable_out));
    dram_chip_model chips (.clk_in(clk_in), .rst_in(rst_in), .row_strobe_in(cs_row_strobe_out),
        .self_refresh_in(self_refresh_out), .refreshing_out(refreshing));

    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    task automatic conclude();
        if (mismatches == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] mask);
        comparisons++;
        if ((got & mask) !== (exp & mask)) begin
            mismatches++;
            $display("BAD at %0t: got %h expected %h mask %h", $time, got, exp, mask);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wr_data_in <= d;
        wr_en_in <= 1'b1;
        @(posedge clk_in);
        wr_en_in <= 1'b0;
    endtask

    task automatic rdb(input logic [7:0] a);
        @(posedge clk_in);
        addr_in <= a;
        rd_en_in <= 1'b1;
        @(posedge clk_in);
        rd_en_in <= 1'b0;
        #1 rd = rd_data_out;
    endtask

    // Pin levels need two sync edges and one more for the derived outputs.
    task automatic settle();
        repeat (5) @(posedge clk_in);
        #1;
    endtask

    task automatic tick();
        @(posedge clk_in);
        refresh_tick_in <= 1'b1;
        @(posedge clk_in);
        refresh_tick_in <= 1'b0;
    endtask

    function automatic logic [7:0] smask(input logic [3:0] a);
        logic [7:0] m;
        for (int i = 0; i < 4; i++) begin
            m[2*i +: 2] = {2{a[i]}};
        end
        return m;
    endfunction

    initial begin
        #400000;
        mismatches++;
        conclude();
    end

    initial begin
        {wr_en_in, rd_en_in, sw_standby_in, hw_standby_in, refresh_tick_in} = 5'h00;
        addr_in = 8'h00;
        wr_data_in = 8'h00;
        expanded_mode_in = 1'b1;
        rst_in = 1'b1;
        repeat (8) @(posedge clk_in);
        rst_in <= 1'b0;
        settle();
        rdb(`DAC_OFF_CTRL_A);
        check(rd, 8'h10, 8'hff);
        rdb(`DAC_OFF_CTRL_B);
        check(rd, 8'h08, 8'hff);
        rdb(`DAC_OFF_TMR_CSR);
        check(rd, 8'h07, 8'hff);
        check({4'h0, cs_port_release_out}, 8'h0f, 8'hff);
        wr(`DAC_OFF_CTRL_A, 8'h00);
        rdb(`DAC_OFF_CTRL_A);
        check(rd, 8'h10, 8'hff);
        wr(8'h05, 8'hff);
        rdb(8'h05);
        check(rd, 8'h00, 8'hff);
        wr(`DAC_OFF_CTRL_B, 8'h35);
        wr(`DAC_OFF_TMR_COR, 8'h02);
        wr(`DAC_OFF_TMR_CSR, 8'h48);
        settle();
        rdb(`DAC_OFF_CTRL_B);
        check(rd, 8'h3d, 8'hff);
        check(ctrl_b_effective_out, 8'h00, 8'hff);
        check({7'h0, cmi_enable_out}, 8'h01, 8'hff);
        repeat (3) tick();
        settle();
        check({7'h0, compare_match_flag_out}, 8'h01, 8'hff);
        // Every code is reached through 000, as software must never hop between nonzero codes.
        for (int c = 0; c < 8; c++) begin
            wr(`DAC_OFF_CTRL_A, 8'h00);
            wr(`DAC_OFF_CTRL_A, {c[2:0], 5'h00});
            settle();
            check({4'h0, area_dram_out}, {4'h0, AREAS[c]}, 8'hff);
            check({4'h0, cs_row_strobe_out}, {4'h0, PINS[c]}, 8'hff);
            check({4'h0, cs_port_release_out}, {4'h0, ~PINS[c]}, 8'hff);
            check(area_strobe_out, STROBES[c], smask(AREAS[c]));
        end
        wr(`DAC_OFF_CTRL_A, 8'h00);
        wr(`DAC_OFF_CTRL_A, 8'h20);
        settle();
        check({7'h0, cmi_enable_out}, 8'h00, 8'hff);
        check(ctrl_b_effective_out, 8'h3d, 8'hf7);
        wr(`DAC_OFF_CTRL_B, 8'h00);
        wr(`DAC_OFF_TMR_COR, 8'hff);
        wr(`DAC_OFF_TMR_CNT, 8'h07);
        rdb(`DAC_OFF_CTRL_B);
        check(rd, 8'h3d, 8'hff);
        rdb(`DAC_OFF_TMR_COR);
        check(rd, 8'h02, 8'hff);
        rdb(`DAC_OFF_TMR_CNT);
        check(rd, 8'h00, 8'hff);
        rdb(`DAC_OFF_TMR_CSR);
        check(rd, 8'h8f, 8'hbf);
        wr(`DAC_OFF_TMR_CSR, 8'h00);
        settle();
        check({7'h0, compare_match_flag_out}, 8'h00, 8'hff);
        rdb(`DAC_OFF_TMR_CSR);
        check(rd, 8'h0f, 8'hbf);
        @(posedge clk_in) expanded_mode_in <= 1'b0;
        settle();
        check({4'h0, area_dram_out}, 8'h00, 8'hff);
        wr(`DAC_OFF_CTRL_B, 8'h11);
        rdb(`DAC_OFF_CTRL_B);
        check(rd, 8'h19, 8'hff);
        @(posedge clk_in) expanded_mode_in <= 1'b1;
        wr(`DAC_OFF_CTRL_A, 8'h2c);
        settle();
        check({6'h0, burst_mode_out, row_down_hold_out}, 8'h03, 8'hff);
        wr(`DAC_OFF_CTRL_A, 8'h28);
        settle();
        check({6'h0, burst_mode_out, row_down_hold_out}, 8'h02, 8'hff);
        wr(`DAC_OFF_CTRL_A, 8'h24);
        settle();
        check({6'h0, burst_mode_out, row_down_hold_out}, 8'h00, 8'hff);
        wr(`DAC_OFF_CTRL_A, 8'h0c);
        settle();
        check({7'h0, burst_mode_out}, 8'h00, 8'hff);
        wr(`DAC_OFF_CTRL_A, 8'h22);
        sw_standby_in <= 1'b1;
        settle();
        check({7'h0, self_refresh_out}, 8'h01, 8'hff);
        check({4'h0, refreshing}, 8'h01, 8'hff);
        rdb(`DAC_OFF_CTRL_A);
        check(rd, 8'h32, 8'hff);
        @(posedge clk_in) sw_standby_in <= 1'b0;
        settle();
        check({3'h0, refreshing, self_refresh_out}, 8'h00, 8'hff);
        wr(`DAC_OFF_CTRL_A, 8'h20);
        sw_standby_in <= 1'b1;
        settle();
        check({7'h0, self_refresh_out}, 8'h00, 8'hff);
        @(posedge clk_in) sw_standby_in <= 1'b0;
        // The refresh pin enable follows bit 0 of control A whatever the area code.
        wr(`DAC_OFF_CTRL_A, 8'h21);
        settle();
        check({7'h0, refresh_pin_out_en_out}, 8'h01, 8'hff);
        wr(`DAC_OFF_CTRL_A, 8'h2d);
        rdb(`DAC_OFF_CTRL_A);
        check(rd, 8'h3d, 8'hff);
        wr(`DAC_OFF_CTRL_A, 8'h20);
        settle();
        check({7'h0, refresh_pin_out_en_out}, 8'h00, 8'hff);
        @(posedge clk_in) hw_standby_in <= 1'b1;
        settle();
        rdb(`DAC_OFF_CTRL_A);
        check(rd, 8'h10, 8'hff);
        rdb(`DAC_OFF_CTRL_B);
        check(rd, 8'h08, 8'hff);
        @(posedge clk_in) hw_standby_in <= 1'b0;
        settle();
        rdb(`DAC_OFF_TMR_COR);
        check(rd, 8'hff, 8'hff);
        conclude();
    end
endmodule
`default_nettype wire
